// ===== shared/flash_link_if.sv
// Serial link between the flash device end and its host.
`default_nettype none
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic rst_n;
    logic so;
    logic so_oe;
    logic rdy_oe;
    logic so_line;
    logic rdy_line;
    // Undriven output and the open-drain ready line both rest high by pull-up.
    assign so_line  = so_oe ? so : 1'b1;
    assign rdy_line = ~rdy_oe;
    modport device (input cs_n, input sck, input si, input rst_n,
                    output so, output so_oe, output rdy_oe);
    modport host   (output cs_n, output sck, output si, output rst_n,
                    input so_line, input rdy_line);
endinterface
`default_nettype wire

// ===== shared/flash_link_pkg.sv
// Constants shared by the flash device end and its host controller.
`default_nettype none
package flash_link_pkg;
    localparam int unsigned CLK_NS       = 5;
    localparam int unsigned XFR_US       = 200;    // transfer_compare_time, max
    localparam int unsigned EP_MS        = 20;     // erase_program_time, max
    localparam int unsigned PROG_MS      = 15;
    localparam int unsigned PERASE_MS    = 10;
    localparam int unsigned BERASE_MS    = 15;
    localparam int unsigned RST_PULSE_US = 10;
    localparam int unsigned REC_US       = 1;      // reset_recovery_time
    localparam int unsigned GAP_NS       = 250;    // select_high_gap, also setup and hold
    localparam int unsigned PWRUP_MS     = 20;
    localparam int unsigned SCK_MAX_KHZ  = 15000;
    localparam int unsigned XFR_CYC      = XFR_US * 1000 / CLK_NS;
    localparam int unsigned EP_CYC       = EP_MS * 1000000 / CLK_NS;
    localparam int unsigned PROG_CYC     = PROG_MS * 1000000 / CLK_NS;
    localparam int unsigned PERASE_CYC   = PERASE_MS * 1000000 / CLK_NS;
    localparam int unsigned BERASE_CYC   = BERASE_MS * 1000000 / CLK_NS;
    localparam int unsigned PWRUP_CYC    = PWRUP_MS * 1000000 / CLK_NS;
    localparam int unsigned RST_CYC      = (RST_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned REC_CYC      = (REC_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned GAP_CYC      = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SCK_HALF_CYC =
        (1000000 + SCK_MAX_KHZ * 2 * CLK_NS - 1) / (SCK_MAX_KHZ * 2 * CLK_NS);
    localparam int unsigned TMR_W        = 23;
    // Opcodes.
    localparam logic [7:0] OP_STATUS   = 8'h57;
    localparam logic [7:0] OP_XFER     = 8'h53;
    localparam logic [7:0] OP_COMPARE  = 8'h60;
    localparam logic [7:0] OP_MEM_PROG = 8'h82;
    localparam logic [7:0] OP_REWRITE  = 8'h58;
    localparam logic [7:0] OP_BUF_PE   = 8'h83;
    localparam logic [7:0] OP_BUF_P    = 8'h88;
    localparam logic [7:0] OP_PERASE   = 8'h81;
    localparam logic [7:0] OP_BERASE   = 8'h50;
    // Command framing.
    localparam int unsigned OPC_BITS   = 8;
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned STAT_FRAME = 16;
    localparam int unsigned PAGE_LSB   = 9;
    localparam int unsigned PAGE_W     = 9;
    localparam int unsigned BYTE_W     = 9;
    // Status byte layout.
    localparam int unsigned ST_RDY  = 7;
    localparam int unsigned ST_COMP = 6;
    localparam int unsigned ST_DEN  = 3;
    localparam logic [2:0]  DENSITY_CODE = 3'h5;   // Arbitrary value.
    // Host register map.
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ADDR     = 8'h04;
    localparam logic [7:0] REG_STAT     = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam int unsigned CTRL_GO    = 8;
    localparam int unsigned CTRL_MODE3 = 9;
    localparam int unsigned CTRL_RST   = 10;
    localparam int unsigned STAT_BUSY  = 8;
    localparam int unsigned STAT_RDY   = 9;
    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_READY  = 1;
endpackage
`default_nettype wire

// ===== src/flash_device.sv
// Device end of the serial flash link: framing, status byte and busy timing.
`default_nettype none
module flash_device
    import flash_link_pkg::*;
#(
    parameter int unsigned XFR_CYCLES    = XFR_CYC,
    parameter int unsigned EP_CYCLES     = EP_CYC,
    parameter int unsigned PROG_CYCLES   = PROG_CYC,
    parameter int unsigned PERASE_CYCLES = PERASE_CYC,
    parameter int unsigned BERASE_CYCLES = BERASE_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    flash_link_if.device              link,
    output logic                      cmd_valid,
    output logic [7:0]                cmd_opcode,
    output logic [PAGE_W-1:0]         cmd_page,
    output logic [BYTE_W-1:0]         cmd_byte,
    input  wire logic                 cmp_differ,
    output logic                      busy,
    output logic                      clock_mode3
);
    logic [1:0]        cs_sync_q, sck_sync_q, si_sync_q, rst_sync_q;
    logic              cs_prev_q, sck_prev_q;
    logic              active_q, mode3_q, stat_rd_q, busy_q, comp_q, cmp_op_q;
    logic [5:0]        cnt_q;
    logic [31:0]       shift_q;
    logic [2:0]        out_idx_q;
    logic              so_q, so_oe_q, valid_q;
    logic [TMR_W-1:0]  timer_q, dur;
    logic              cs_fall, cs_rise, sck_rise, sck_fall, clr, timed, launch;
    logic [7:0]        status, opc;

    // Each pin passes two flops; only the second stage is looked at.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_q  <= 2'h3;
            sck_sync_q <= 2'h3;
            si_sync_q  <= 2'h0;
            rst_sync_q <= 2'h3;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b1;
        end else begin
            cs_sync_q  <= {cs_sync_q[0], link.cs_n};
            sck_sync_q <= {sck_sync_q[0], link.sck};
            si_sync_q  <= {si_sync_q[0], link.si};
            rst_sync_q <= {rst_sync_q[0], link.rst_n};
            cs_prev_q  <= cs_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end

    assign clr      = ~rst_sync_q[1];
    assign cs_fall  = cs_prev_q & ~cs_sync_q[1];
    assign cs_rise  = ~cs_prev_q & cs_sync_q[1];
    assign sck_rise = active_q & ~sck_prev_q & sck_sync_q[1];
    assign sck_fall = active_q & sck_prev_q & ~sck_sync_q[1];
    assign opc      = shift_q[31:24];
    assign status   = {~busy_q, comp_q, DENSITY_CODE, 3'h0};

    // Mode follows the idle clock level seen at select fall.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode3_q <= 1'b1;
        end else if (clr) begin
            mode3_q <= 1'b1;
        end else if (cs_fall) begin
            mode3_q <= sck_sync_q[1];
        end
    end

    // Serial activity counts only inside a frame opened by select fall.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else if (clr || cs_rise) begin
            active_q <= 1'b0;
        end else if (cs_fall) begin
            active_q <= 1'b1;
        end
    end

    // Both modes capture on the rising clock; the frame is opcode then address bytes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= 6'h0;
            shift_q <= 32'h0;
        end else if (clr || cs_fall) begin
            cnt_q   <= 6'h0;
        end else if (sck_rise && cnt_q != 6'(FRAME_BITS)) begin
            shift_q <= {shift_q[30:0], si_sync_q[1]};
            cnt_q   <= cnt_q + 6'h1;
        end
    end

    // Status stream: bit 7 first, wraps and shows the live byte each pass.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_rd_q <= 1'b0;
            out_idx_q <= 3'h7;
            so_q      <= 1'b1;
            so_oe_q   <= 1'b0;
        end else if (clr || !active_q) begin
            stat_rd_q <= 1'b0;
            out_idx_q <= 3'h7;
            so_oe_q   <= 1'b0;
        end else if (sck_rise && cnt_q == 6'(OPC_BITS - 1)) begin
            stat_rd_q <= {shift_q[6:0], si_sync_q[1]} == OP_STATUS;
        end else if (sck_fall && stat_rd_q) begin
            so_q      <= status[out_idx_q];
            so_oe_q   <= 1'b1;
            out_idx_q <= out_idx_q - 3'h1;
        end
    end

    always_comb begin
        timed = 1'b1;
        dur   = TMR_W'(EP_CYCLES);
        unique case (opc)
            OP_XFER, OP_COMPARE: dur = TMR_W'(XFR_CYCLES);
            OP_MEM_PROG, OP_REWRITE, OP_BUF_PE: dur = TMR_W'(EP_CYCLES);
            OP_BUF_P: dur = TMR_W'(PROG_CYCLES);
            OP_PERASE: dur = TMR_W'(PERASE_CYCLES);
            OP_BERASE: dur = TMR_W'(BERASE_CYCLES);
            default: timed = 1'b0;
        endcase
    end

    // Reserved top address bits never reach the command outputs.
    assign launch = active_q && cs_rise && cnt_q == 6'(FRAME_BITS) && !busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q    <= 1'b0;
            cmd_opcode <= 8'h0;
            cmd_page   <= '0;
            cmd_byte   <= '0;
        end else begin
            valid_q <= launch && !clr;
            if (launch) begin
                cmd_opcode <= opc;
                cmd_page   <= shift_q[PAGE_LSB +: PAGE_W];
                cmd_byte   <= shift_q[BYTE_W-1:0];
            end
        end
    end

    // Busy is set in the cycle after select rise is seen, about 15 ns after the pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q   <= 1'b0;
            timer_q  <= '0;
            cmp_op_q <= 1'b0;
        end else if (clr) begin
            busy_q   <= 1'b0;
            cmp_op_q <= 1'b0;
        end else if (launch && timed) begin
            busy_q   <= 1'b1;
            timer_q  <= dur - TMR_W'(1);
            cmp_op_q <= opc == OP_COMPARE;
        end else if (busy_q) begin
            if (timer_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                timer_q <= timer_q - TMR_W'(1);
            end
        end
    end

    // Compare result is kept through reset of the link and only moves on a compare.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_q <= 1'b0;
        end else if (busy_q && cmp_op_q && timer_q == '0 && !clr) begin
            comp_q <= cmp_differ;
        end
    end

    assign cmd_valid   = valid_q;
    assign busy        = busy_q;
    assign clock_mode3 = mode3_q;
    assign link.so     = so_q;
    assign link.so_oe  = so_oe_q;
    assign link.rdy_oe = busy_q;
endmodule
`default_nettype wire

// ===== src/flash_host.sv
// Host end of the serial flash link with an APB register front.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
module flash_host
    import flash_link_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    flash_link_if.host       link
);
    typedef enum logic [7:0] {
        S_PWR = 8'h01, S_IDLE = 8'h02, S_RST = 8'h04, S_REC = 8'h08,
        S_SETUP = 8'h10, S_SHIFT = 8'h20, S_HOLD = 8'h40, S_GAP = 8'h80
    } state_t;

    state_t            state_q;
    logic [TMR_W-1:0]  wait_q;
    logic [2:0]        hc_q;
    logic [5:0]        bit_q;
    logic              phase_q, mode3_q, stat_op_q, done_q;
    logic [31:0]       tx_q, addr_q, prdata_q;
    logic [7:0]        opc_q, rx_q, stat_q;
    logic [1:0]        so_sync_q, rdy_sync_q, irq_st_q, irq_mask_q;
    logic              rdy_prev_q, cs_n_q, sck_q, si_q, rst_n_q;
    logic              wr, wr_ctrl, mapped, wait_end, half_end, last;

    assign wr       = psel & penable & pwrite;
    assign wr_ctrl  = wr && paddr == REG_CTRL;
    assign mapped   = paddr == REG_CTRL || paddr == REG_ADDR || paddr == REG_STAT
                      || paddr == REG_IRQ_STAT || paddr == REG_IRQ_MASK;
    assign wait_end = wait_q == '0;
    assign half_end = hc_q == 3'(SCK_HALF_CYC - 1);
    assign last     = bit_q == (stat_op_q ? 6'(STAT_FRAME - 1) : 6'(FRAME_BITS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_sync_q  <= 2'h3;
            rdy_sync_q <= 2'h3;
            rdy_prev_q <= 1'b1;
        end else begin
            so_sync_q  <= {so_sync_q[0], link.so_line};
            rdy_sync_q <= {rdy_sync_q[0], link.rdy_line};
            rdy_prev_q <= rdy_sync_q[1];
        end
    end

    // Sequencer: every timed wait shares one down-counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= S_PWR;
            wait_q    <= TMR_W'(PWRUP_CYCLES);
            cs_n_q    <= 1'b1;
            sck_q     <= 1'b1;
            si_q      <= 1'b0;
            rst_n_q   <= 1'b1;
            hc_q      <= 3'h0;
            bit_q     <= 6'h0;
            phase_q   <= 1'b0;
            tx_q      <= 32'h0;
            rx_q      <= 8'h0;
            stat_op_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!wait_end) begin
                wait_q <= wait_q - TMR_W'(1);
            end
            unique case (state_q)
                S_PWR: if (wait_end) state_q <= S_IDLE;
                S_IDLE: begin
                    sck_q <= mode3_q;
                    if (wr_ctrl && pwdata[CTRL_RST]) begin
                        rst_n_q <= 1'b0;
                        wait_q  <= TMR_W'(RST_CYC);
                        state_q <= S_RST;
                    end else if (wr_ctrl && pwdata[CTRL_GO]) begin
                        // A mode written with GO must already show at the select fall.
                        sck_q     <= pwdata[CTRL_MODE3];
                        stat_op_q <= pwdata[7:0] == OP_STATUS;
                        tx_q      <= {pwdata[7:0], addr_q[23:0]};
                        cs_n_q    <= 1'b0;
                        wait_q    <= TMR_W'(GAP_CYC);
                        state_q   <= S_SETUP;
                    end
                end
                S_RST: if (wait_end) begin
                    rst_n_q <= 1'b1;
                    wait_q  <= TMR_W'(REC_CYC);
                    state_q <= S_REC;
                end
                S_REC: if (wait_end) state_q <= S_IDLE;
                S_SETUP: if (wait_end) begin
                    sck_q   <= 1'b0;
                    si_q    <= tx_q[31];
                    hc_q    <= 3'h0;
                    phase_q <= 1'b0;
                    bit_q   <= 6'h0;
                    state_q <= S_SHIFT;
                end
                S_SHIFT: begin
                    hc_q <= half_end ? 3'h0 : hc_q + 3'h1;
                    if (half_end && !phase_q) begin
                        sck_q   <= 1'b1;
                        phase_q <= 1'b1;
                    end else if (half_end) begin
                        // Output changes on the falling edge, so the slot end still sees it.
                        if (bit_q >= 6'(OPC_BITS)) begin
                            rx_q <= {rx_q[6:0], so_sync_q[1]};
                        end
                        if (last) begin
                            sck_q   <= mode3_q;
                            wait_q  <= TMR_W'(GAP_CYC);
                            state_q <= S_HOLD;
                        end else begin
                            sck_q   <= 1'b0;
                            phase_q <= 1'b0;
                            bit_q   <= bit_q + 6'h1;
                            tx_q    <= {tx_q[30:0], 1'b0};
                            si_q    <= tx_q[30];
                        end
                    end
                end
                S_HOLD: if (wait_end) begin
                    cs_n_q  <= 1'b1;
                    wait_q  <= TMR_W'(GAP_CYC);
                    state_q <= S_GAP;
                end
                S_GAP: if (wait_end) begin
                    done_q  <= 1'b1;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode3_q    <= 1'b1;
            opc_q      <= 8'h0;
            addr_q     <= 32'h0;
            irq_mask_q <= 2'h0;
        end else if (wr) begin
            if (paddr == REG_CTRL) begin
                mode3_q <= pwdata[CTRL_MODE3];
                opc_q   <= pwdata[7:0];
            end
            if (paddr == REG_ADDR) addr_q <= {8'h0, pwdata[23:0]};
            if (paddr == REG_IRQ_MASK) irq_mask_q <= pwdata[1:0];
        end
    end

    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= 2'h0;
            stat_q   <= 8'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr && paddr == REG_IRQ_STAT) ? pwdata[1:0] : 2'h0))
                        | {rdy_sync_q[1] & ~rdy_prev_q, done_q};
            // Taken as the sequencer returns to idle, so a poll that sees idle sees it too.
            if (state_q == S_GAP && wait_end && stat_op_q) stat_q <= rx_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable) begin
            unique case (paddr)
                REG_CTRL:     prdata_q <= {21'h0, 1'b0, mode3_q, 1'b0, opc_q};
                REG_ADDR:     prdata_q <= addr_q;
                REG_STAT:     prdata_q <= {22'h0, rdy_sync_q[1], state_q != S_IDLE, stat_q};
                REG_IRQ_STAT: prdata_q <= {30'h0, irq_st_q};
                REG_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
                default:      prdata_q <= 32'h0;
            endcase
        end
    end

    assign prdata     = prdata_q;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;
    assign irq        = |(irq_st_q & irq_mask_q);
    assign link.cs_n  = cs_n_q;
    assign link.sck   = sck_q;
    assign link.si    = si_q;
    assign link.rst_n = rst_n_q;
endmodule
`default_nettype wire

// ===== verification/flash_link_monitor.sv
// Concurrent checks on the serial link between the flash host and device ends.
`default_nettype none
module flash_link_monitor #(
    parameter int unsigned BUSY_MAX = 61
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic rst_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic rdy_oe
);
    logic [7:0] busy_q;
    logic [5:0] rise_q;
    logic [5:0] gap_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // The gap count starts saturated so the first frame after reset is not flagged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 8'h00;
            rise_q <= 6'h00;
            gap_q  <= 6'h3f;
        end else begin
            busy_q <= rdy_oe ? busy_q + 8'h01 : 8'h00;
            rise_q <= cs_n ? 6'h00 : rise_q + {5'h00, $rose(sck)};
            gap_q  <= !cs_n ? 6'h00 : ((gap_q == 6'h3f) ? gap_q : gap_q + 6'h01);
        end
    end
    so_idle_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("serial output driven while deselected");
    rdy_reset_a: assert property (!rst_n [*5] |-> !rdy_oe)
        else $error("busy line held during link reset");
    busy_launch_a: assert property ($rose(rdy_oe) |-> cs_n && !$past(cs_n, 40))
        else $error("busy line not tied to a recent select rise");
    busy_bound_a: assert property (busy_q <= BUSY_MAX)
        else $error("busy line held too long");
    frame_len_a: assert property ($rose(cs_n) |-> rise_q == 6'd32 || rise_q == 6'd16)
        else $error("frame length not 16 or 32 clock rises");
    cs_gap_a: assert property ($fell(cs_n) |-> gap_q >= 6'd49)
        else $error("select high gap too short");
    si_hold_a: assert property (!cs_n && $rose(sck) |=> $stable(si) [*5])
        else $error("serial input moved near clock rise");
    so_hold_a: assert property (so_oe && $rose(sck) |=> $stable(so) [*4])
        else $error("serial output moved while clock high");
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Bench joining the flash host and device ends, driven over APB and the compare input, checked over APB and at the ports of both ends.
`default_nettype none
module tb
    import flash_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  OPS [9] = '{8'h53, 8'h60, 8'h60, 8'h82, 8'h58, 8'h83, 8'h88,
                                        8'h81, 8'h50};
    localparam int unsigned DUR [9] = '{40, 40, 40, 60, 60, 60, 50, 30, 45};
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("ERROR %s expected %h seen %h", n, e, g); \
    end \
end
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic              cmp_differ = 1'b0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              cmd_valid;
    logic [7:0]        cmd_opcode;
    logic [PAGE_W-1:0] cmd_page;
    logic [BYTE_W-1:0] cmd_byte;
    logic              busy;
    logic              clock_mode3;
    logic [31:0]       rv;
    logic              ev;
    logic              m3 = 1'b1;
    int                bcnt = 0;
    int                cyc = 0;
    int                miscompares = 0;
    int                cmp_count = 0;
    flash_link_if flash_link_if_i ();
    flash_host #(.PWRUP_CYCLES(10)) flash_host_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(flash_link_if_i));
    flash_device #(.XFR_CYCLES(DUR[0]), .EP_CYCLES(DUR[3]), .PROG_CYCLES(DUR[6]),
        .PERASE_CYCLES(DUR[7]), .BERASE_CYCLES(DUR[8])) flash_device_i (.pclk(pclk),
        .presetn(presetn),
        .link(flash_link_if_i), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_page(cmd_page), .cmd_byte(cmd_byte), .cmp_differ(cmp_differ), .busy(busy),
        .clock_mode3(clock_mode3));
    // The checker's default busy ceiling already covers the longest duration here.
    flash_link_monitor flash_link_monitor_i (.pclk(pclk), .presetn(presetn),
        .cs_n(flash_link_if_i.cs_n), .sck(flash_link_if_i.sck), .si(flash_link_if_i.si),
        .rst_n(flash_link_if_i.rst_n), .so(flash_link_if_i.so), .so_oe(flash_link_if_i.so_oe),
        .rdy_oe(flash_link_if_i.rdy_oe));
    initial forever #2.5 pclk = ~pclk;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // A hung handshake ends here rather than stalling the run.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end
    // Busy length is measured apart from the APB traffic that runs beside it.
    always @(posedge pclk) begin
        if (cmd_valid === 1'b1) bcnt <= 1;
        else if (busy === 1'b1) bcnt <= bcnt + 1;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic idle();
        do apb(1'b0, REG_STAT, 32'h0); while (rv[STAT_BUSY] !== 1'b0);
    endtask
    task automatic stat(input logic [7:0] exp);
        // GO is ignored until the power-up or reset wait is over.
        idle();
        wr(REG_CTRL, {22'h0, m3, 1'b1, OP_STATUS});
        idle();
        `CHK("status", {22'h0, 2'b10, exp}, rv)
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("mode", 1'b1, clock_mode3)
        `CHK("so_line", 1'b1, flash_link_if_i.so_line)
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl", 32'h200, rv)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("slverr", 1'b1, ev)
        stat({2'b10, DENSITY_CODE, 3'h0});
        `CHK("mode", 1'b1, clock_mode3)
        m3 = 1'b0;
        stat({2'b10, DENSITY_CODE, 3'h0});
        `CHK("mode", 1'b0, clock_mode3)
        wr(REG_IRQ_MASK, 32'h1);
        for (int i = 0; i < 9; i++) begin
            cmp_differ <= (i == 1);
            wr(REG_ADDR, {8'h0, 6'h3f, 9'(i * 37 + 5), 9'(i * 29 + 3)});
            wr(REG_IRQ_STAT, 32'h3);
            wr(REG_CTRL, {22'h0, m3, 1'b1, OPS[i]});
            while (cmd_valid !== 1'b1) @(posedge pclk);
            `CHK("opcode", OPS[i], cmd_opcode)
            `CHK("page", 9'(i * 37 + 5), cmd_page)
            `CHK("byte", 9'(i * 29 + 3), cmd_byte)
            repeat (6) @(posedge pclk);
            apb(1'b0, REG_STAT, 32'h0);
            `CHK("ready_line", 1'b0, rv[STAT_RDY])
            while (busy !== 1'b0) @(posedge pclk);
            `CHK("busy_len", DUR[i], bcnt)
            idle();
            `CHK("irq", 1'b1, irq)
            wr(REG_IRQ_STAT, 32'h3);
            `CHK("irq", 1'b0, irq)
            stat({1'b1, i == 1, DENSITY_CODE, 3'h0});
        end
        wr(REG_IRQ_MASK, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(REG_CTRL, 32'h400);
        idle();
        `CHK("mode", 1'b1, clock_mode3)
        stat({2'b10, DENSITY_CODE, 3'h0});
        `CHK("mode", 1'b0, clock_mode3)
        complete_run();
    end
endmodule
`default_nettype wire
